// >>> spf_params.svh
// Purpose: Constants of the supply pulse fuse programmer.
// Assumes: 20 MHz ref_clk; level comparators sit outside this logic.
// Notes:   Times are in ns; cycle counts derive from them.
// Functional notes
// - Device decodes low, mid and high supply levels as its only input.
// - Every pulse ends with a return to low, which delimits it.
// - Try behaviour sets several parameters at once, applied immediately.
// - Try values are volatile and clear when the supply is cycled.
// - Blow behaviour sets one parameter to a single set bit, then blows that one fuse.
// - Further parameters are made permanent one blow operation at a time.
// - After lock every programming attempt is ignored forever.
// - Lock comes from blowing the lock fuse through the blow procedure.
// - Registers each select a behaviour or one parameter.
// - Each register owns a binary fuse field; incrementing changes it.
// - Only complete pulse sequences program; stray glitches do nothing.
// - Select: high pulse, mid pulses counting the key, high pulse.
// - Next high pulse enters addressing; each mid end adds one, saturating.
// - Long high pulse blows the single addressed bit; cycle supply after.
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH
`define SPF_NUM_REG   5
`define SPF_FIELD_W   6
`define SPF_KEY_TRY   3'h6
`define SPF_KEY_BLOW  3'h7
`define SPF_LOCK_REG  4
`define SPF_LOCK_BIT  0
`define SPF_CLK_NS    50
`define SPF_FILT_NS   20000
`define SPF_BLOW_NS   40000
`define SPF_FILT_CYC  ((`SPF_FILT_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS)
`define SPF_BLOW_CYC  ((`SPF_BLOW_NS + `SPF_CLK_NS - 1) / `SPF_CLK_NS)
`endif

// >>> spf_pkg.sv
// Purpose: Types of the supply pulse fuse programmer.
// Assumes: spf_params.svh supplies the sizes.
// Notes:   All decoder state lives in one packed struct.
`include "spf_params.svh"
package spf_pkg;
  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MID  = 2'h1,
    LVL_HIGH = 2'h2
  } lvl_type;

  // Gray codes along idle, select, selected, address, blow, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SEL  = 3'h1,
    ST_SELD = 3'h3,
    ST_ADDR = 3'h2,
    ST_BLOW = 3'h6,
    ST_DONE = 3'h7
  } state_type;

  typedef struct packed {
    logic                                        mid_s1;
    logic                                        mid_s2;
    logic                                        high_s1;
    logic                                        high_s2;
    logic [`SPF_NUM_REG*`SPF_FIELD_W-1:0]        fuse_s1;
    logic [`SPF_NUM_REG*`SPF_FIELD_W-1:0]        fuse_s2;
    lvl_type                                     cand;
    logic [9:0]                                  filt_cnt;
    lvl_type                                     lvl;
    lvl_type                                     peak;
    state_type                                   st;
    logic                                        blow_mode;
    logic [2:0]                                  key;
    logic [2:0]                                  sel;
    logic [`SPF_NUM_REG-1:0][`SPF_FIELD_W-1:0]   vol;
    logic [9:0]                                  dur;
    logic                                        blow_fire;
    logic [2:0]                                  blow_reg;
    logic [2:0]                                  blow_bit;
    logic [`SPF_NUM_REG*`SPF_FIELD_W-1:0]        param_val;
    logic                                        locked;
  } spf_state_type;
endpackage : spf_pkg

// >>> supply_pulse_fuse_programmer.sv
// Purpose: Decode supply level pulses into try, blow and lock programming.
// Assumes: Comparators flag mid and high supply; fuse states are sensed.
// Notes:   rst_n is the power-up reset; fuses live outside this logic.
`timescale 1ns/1ps
`include "spf_params.svh"
module supply_pulse_fuse_programmer (
  input  wire logic                                 ref_clk,    // 20 MHz
  input  wire logic                                 rst_n,      // Power-up
  input  wire logic                                 lvl_mid,    // Supply >= mid
  input  wire logic                                 lvl_high,   // Supply >= high
  input  wire logic [`SPF_NUM_REG*`SPF_FIELD_W-1:0] fuse_sense, // Blown fuses
  output logic      [`SPF_NUM_REG*`SPF_FIELD_W-1:0] param_val,  // Fuse or try
  output logic                                      blow_fire,  // Blow strobe
  output logic      [2:0]                           blow_reg,   // Reg index
  output logic      [2:0]                           blow_bit,   // Bit index
  output logic                                      locked      // Lock fuse
);

  // Short names keep the field slicing readable
  localparam int NR = `SPF_NUM_REG;
  localparam int FW = `SPF_FIELD_W;

  spf_pkg::spf_state_type r_ff;
  spf_pkg::spf_state_type nxt_r;
  logic [NR*FW-1:0]       eff_val;

  // Each register's value is its blown fuses ORed with the volatile field
  generate
    for (genvar g = 0; g < NR; g++)
    begin : g_eff
      assign eff_val[g*FW +: FW] = r_ff.fuse_s2[g*FW +: FW] | r_ff.vol[g];
    end
  endgenerate

  // Next state of the whole decoder, built from one copy of the struct
  // Filtering comes before decoding so a supply glitch cannot fake a pulse
  always_comb
  begin
    spf_pkg::lvl_type raw;
    logic             pulse_end;
    logic             high_start;
    logic [FW-1:0]    cur;
    logic             one_hot;
    logic [2:0]       bit_idx;
    raw        = spf_pkg::LVL_LOW;
    pulse_end  = 1'b0;
    high_start = 1'b0;
    cur        = '0;
    one_hot    = 1'b0;
    bit_idx    = 3'h0;
    nxt_r      = r_ff;
    // Strobe defaults low so it lasts exactly one cycle
    nxt_r.blow_fire = 1'b0;

    // Two-stage synchronisers; first stages feed only the second
    nxt_r.mid_s1  = lvl_mid;
    nxt_r.mid_s2  = r_ff.mid_s1;
    nxt_r.high_s1 = lvl_high;
    nxt_r.high_s2 = r_ff.high_s1;
    nxt_r.fuse_s1 = fuse_sense;
    nxt_r.fuse_s2 = r_ff.fuse_s1;
    nxt_r.locked  = r_ff.fuse_s2[`SPF_LOCK_REG*FW + `SPF_LOCK_BIT];

    // Classify the supply into three levels
    if (r_ff.high_s2)
      raw = spf_pkg::LVL_HIGH;
    else if (r_ff.mid_s2)
      raw = spf_pkg::LVL_MID;
    else
      raw = spf_pkg::LVL_LOW;

    // Level must hold for the filter window; glitches never reach lvl
    if (raw != r_ff.cand)
    begin
      nxt_r.cand     = raw;
      nxt_r.filt_cnt = 10'h000;
    end
    else if (r_ff.filt_cnt < 10'(`SPF_FILT_CYC - 1))
      nxt_r.filt_cnt = r_ff.filt_cnt + 10'h001;
    else
      nxt_r.lvl = r_ff.cand;

    // Peak level tracks a ramp through mid on its way to high
    if (nxt_r.lvl == spf_pkg::LVL_LOW)
    begin
      nxt_r.peak = spf_pkg::LVL_LOW;
      pulse_end  = (r_ff.lvl != spf_pkg::LVL_LOW);
    end
    else if (nxt_r.lvl == spf_pkg::LVL_HIGH)
      nxt_r.peak = spf_pkg::LVL_HIGH;
    else if (r_ff.peak == spf_pkg::LVL_LOW)
      nxt_r.peak = spf_pkg::LVL_MID;
    high_start = (nxt_r.lvl == spf_pkg::LVL_HIGH) &&
                 (r_ff.lvl != spf_pkg::LVL_HIGH);

    // Addressed bit must be a single bit for a blow
    cur     = r_ff.vol[r_ff.sel];
    one_hot = (cur != '0) && ((cur & (cur - 1'b1)) == '0);
    for (int i = 0; i < FW; i++)
    begin
      if (cur[i])
        bit_idx = 3'(i);
    end

    // Pulse decoder: selection, addressing, blow and the terminal state
    case (r_ff.st)
      spf_pkg::ST_IDLE:
      begin
        // A lock fuse already sensed refuses the very first high pulse
        if (!r_ff.locked && pulse_end && r_ff.peak == spf_pkg::LVL_HIGH)
        begin
          nxt_r.st  = spf_pkg::ST_SEL;
          nxt_r.key = 3'h0;
        end
      end
      spf_pkg::ST_SEL:
      begin
        if (pulse_end && r_ff.peak == spf_pkg::LVL_MID)
        begin
          if (r_ff.key != 3'h7)
            nxt_r.key = r_ff.key + 3'h1;
        end
        else if (pulse_end && r_ff.key == `SPF_KEY_TRY)
        begin
          nxt_r.blow_mode = 1'b0;
          nxt_r.st        = spf_pkg::ST_IDLE;
        end
        else if (pulse_end && r_ff.key == `SPF_KEY_BLOW)
        begin
          nxt_r.blow_mode = 1'b1;
          nxt_r.st        = spf_pkg::ST_IDLE;
        end
        else if (pulse_end && r_ff.key != 3'h0 && r_ff.key <= 3'(NR))
        begin
          nxt_r.sel = r_ff.key - 3'h1;
          nxt_r.st  = spf_pkg::ST_SELD;
        end
        else if (pulse_end)
          nxt_r.key = 3'h0; // Unmapped key restarts the selection
      end
      spf_pkg::ST_SELD:
      begin
        if (pulse_end && r_ff.peak == spf_pkg::LVL_HIGH)
          nxt_r.st = spf_pkg::ST_ADDR;
      end
      spf_pkg::ST_ADDR:
      begin
        if (pulse_end && r_ff.peak == spf_pkg::LVL_MID)
        begin
          // Saturate at all ones instead of wrapping back to zero
          if (cur != {FW{1'b1}})
            nxt_r.vol[r_ff.sel] = cur + 1'b1;
        end
        else if (high_start && r_ff.blow_mode)
        begin
          nxt_r.st  = spf_pkg::ST_BLOW;
          nxt_r.dur = 10'h000;
        end
        else if (pulse_end && r_ff.peak == spf_pkg::LVL_HIGH)
        begin
          // Try mode lets another register be picked; values stay applied
          nxt_r.st  = spf_pkg::ST_SEL;
          nxt_r.key = 3'h0;
        end
      end
      spf_pkg::ST_BLOW:
      begin
        // Count only qualified high time; a short blow pulse fires nothing
        if (r_ff.lvl == spf_pkg::LVL_HIGH)
        begin
          if (r_ff.dur < 10'(`SPF_BLOW_CYC - 1))
            nxt_r.dur = r_ff.dur + 10'h001;
          else if (r_ff.dur == 10'(`SPF_BLOW_CYC - 1))
          begin
            nxt_r.dur       = r_ff.dur + 10'h001;
            nxt_r.blow_fire = one_hot;
            nxt_r.blow_reg  = r_ff.sel;
            nxt_r.blow_bit  = bit_idx;
          end
        end
        if (pulse_end)
          nxt_r.st = spf_pkg::ST_DONE;
      end
      spf_pkg::ST_DONE:
      begin
        // Only a supply cycle or the lock leaves here, so one bit per power-up
        nxt_r.st = spf_pkg::ST_DONE;
      end
      default:
      begin
        nxt_r.st = spf_pkg::ST_IDLE;
      end
    endcase

    // Lock stops every later sequence and drops volatile values
    if (r_ff.locked)
    begin
      nxt_r.st        = spf_pkg::ST_IDLE;
      nxt_r.vol       = '0;
      nxt_r.blow_fire = 1'b0;
    end
    nxt_r.param_val = eff_val;
  end

  // Power-up clears decoder and try values; fuse state stays outside
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end

  // Outputs come straight from the state register
  assign param_val = r_ff.param_val;
  assign blow_fire = r_ff.blow_fire;
  assign blow_reg  = r_ff.blow_reg;
  assign blow_bit  = r_ff.blow_bit;
  assign locked    = r_ff.locked;

endmodule : supply_pulse_fuse_programmer

// >>> spf_monitor.sv
// Purpose: Assertion checker on the programmer ports
// Assumes: Raw supply flags and sensed fuses seen at the ports
// Notes:   Small counters stand in for long repetitions
`timescale 1ns/1ps
`include "spf_params.svh"
module spf_monitor (
  input wire logic        ref_clk,    // Clock
  input wire logic        rst_n,      // Reset
  input wire logic        lvl_mid,    // Mid flag
  input wire logic        lvl_high,   // High flag
  input wire logic [29:0] fuse_sense, // Fuses
  input wire logic [29:0] param_val,  // Values
  input wire logic        blow_fire,  // Strobe
  input wire logic [2:0]  blow_reg,   // Reg
  input wire logic [2:0]  blow_bit,   // Bit
  input wire logic        locked      // Lock
);
  logic [10:0] hi_cnt; // Raw high cycles
  logic [9:0]  lo_cnt; // Raw low cycles
  logic [3:0]  up_cnt; // Cycles since reset
  // Restart with reset, since the decoder requalifies levels then
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      hi_cnt <= 11'h0;
      lo_cnt <= 10'h0;
      up_cnt <= 4'h0;
    end
    else
    begin
      hi_cnt <= lvl_high ? hi_cnt + {10'h0, hi_cnt != 11'h7FF} : 11'h0;
      lo_cnt <= lvl_mid ? 10'h0 : lo_cnt + {9'h0, lo_cnt != 10'h3FF};
      up_cnt <= up_cnt + {3'h0, up_cnt != 4'hF};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_fire_one_cycle: assert property (blow_fire |=> !blow_fire)
    else $error("blow strobe too long");
  chk_fire_long_high: assert property (blow_fire |-> hi_cnt >= 1190)
    else $error("blow without a long high pulse");
  chk_fire_index_ok: assert property (blow_fire |-> blow_bit < 6 && blow_reg < 5)
    else $error("blow index out of range");
  chk_index_held: assert property (!$rose(blow_fire) |-> $stable(blow_reg) && $stable(blow_bit))
    else $error("blow index moved without a blow");
  chk_lock_sticky: assert property (locked |=> locked)
    else $error("lock dropped");
  chk_lock_from_fuse: assert property ($rose(locked) |->
    $past(fuse_sense[`SPF_LOCK_REG*`SPF_FIELD_W+`SPF_LOCK_BIT], 3))
    else $error("lock without lock fuse");
  chk_no_blow_locked: assert property (locked |-> !blow_fire)
    else $error("blow while locked");
  chk_fuse_kept: assert property (up_cnt == 4'hF && fuse_sense == $past(fuse_sense, 6) |-> (param_val & fuse_sense) == fuse_sense)
    else $error("blown fuse missing from value");
  chk_value_on_low: assert property ($changed(param_val) && up_cnt == 4'hF && fuse_sense == $past(fuse_sense, 8) |-> lo_cnt >= 400)
    else $error("value changed without a qualified low");
endmodule : spf_monitor

// >>> supply_programmer_model.sv
// Purpose: Behavioural supply programmer with the fuse array
// Assumes: Flags change at the falling edge
// Notes:   Fuses persist across device resets, as real fuses do
`timescale 1ns/1ps
`include "spf_params.svh"
module supply_programmer_model (
  input  wire logic        ref_clk,    // Clock
  input  wire logic        blow_fire,  // Strobe
  input  wire logic [2:0]  blow_reg,   // Reg
  input  wire logic [2:0]  blow_bit,   // Bit
  output logic             lvl_mid,    // Supply >= mid
  output logic             lvl_high,   // Supply >= high
  output logic      [29:0] fuse_sense  // Fuses
);
  logic        mid_drv  = 1'b0;  // Supply at or above mid
  logic        high_drv = 1'b0;  // Supply at high
  logic [29:0] fuse_arr = 30'h0; // Blown fuse array
  // Single writer per signal; the pulse task owns the supply levels
  assign lvl_mid    = mid_drv;
  assign lvl_high   = high_drv;
  assign fuse_sense = fuse_arr;
  // One fuse per strobe; a blown fuse never clears
  always @(posedge ref_clk)
    if (blow_fire === 1'b1)
      fuse_arr[blow_reg * `SPF_FIELD_W + blow_bit] <= 1'b1;
  // Low, level, low; the trailing low delimits the pulse
  task automatic pulse(input logic hi, input int len);
  begin
    @(negedge ref_clk);
    mid_drv = 1'b1;
    high_drv = hi;
    repeat (len) @(negedge ref_clk);
    mid_drv = 1'b0;
    high_drv = 1'b0;
    repeat (800) @(negedge ref_clk);
  end
  endtask : pulse
endmodule : supply_programmer_model

// >>> tb_supply_pulse_fuse_programmer.sv
// Purpose: Self-checking bench for the pulse fuse programmer
// Assumes: The model drives supply flags; the bench owns reset
// Notes:   800 cycles are 40 us at 20 MHz
`timescale 1ns/1ps
module tb_supply_pulse_fuse_programmer;
  logic        ref_clk = 1'b0; // Clock
  logic        rst_n = 1'b0;   // Reset
  logic        lvl_mid;        // Mid flag
  logic        lvl_high;       // High flag
  logic [29:0] fuse_sense;     // Fuses
  logic [29:0] param_val;      // Values
  logic        blow_fire;      // Strobe
  logic [2:0]  blow_reg;       // Reg
  logic [2:0]  blow_bit;       // Bit
  logic        locked;         // Lock
  int          bad_count = 0;  // Mismatches
  int          n_tests = 0;    // Compares
  always #25 ref_clk = ~ref_clk;
  supply_pulse_fuse_programmer dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .lvl_mid(lvl_mid), .lvl_high(lvl_high), .fuse_sense(fuse_sense),
    .param_val(param_val), .blow_fire(blow_fire), .blow_reg(blow_reg),
    .blow_bit(blow_bit), .locked(locked));
  supply_programmer_model prog_u (.ref_clk(ref_clk), .blow_fire(blow_fire),
    .blow_reg(blow_reg), .blow_bit(blow_bit), .lvl_mid(lvl_mid),
    .lvl_high(lvl_high), .fuse_sense(fuse_sense));
  task check(input logic [29:0] got, input logic [29:0] exp);
  begin
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  end
  endtask : check
  task end_sim;
  begin
    $display("Compares %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask : end_sim
  // Power-up reset, four cycles
  task do_reset;
  begin
    @(negedge ref_clk);
    rst_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
  end
  endtask : do_reset
  // High, key count of mid pulses, high, then addressing high
  task sel(input int key);
  begin
    prog_u.pulse(1'b1, 800);
    repeat (key) prog_u.pulse(1'b0, 800);
    prog_u.pulse(1'b1, 800);
    prog_u.pulse(1'b1, 800);
  end
  endtask : sel
  // Long high pulse; strobe looked at in its single cycle
  task blow(input logic [2:0] er, input logic [2:0] eb);
    int n;
  begin
    n = 0;
    fork
      prog_u.pulse(1'b1, 1400);
      begin
        while (blow_fire !== 1'b1 && n < 2000)
        begin
          @(negedge ref_clk);
          n++;
        end
        check({blow_fire, blow_reg, blow_bit}, {1'b1, er, eb});
        @(negedge ref_clk);
        check(blow_fire, 1'b0);
      end
    join
  end
  endtask : blow
  task try_mode;
  begin
    do_reset;
    sel(1);
    repeat (3) prog_u.pulse(1'b0, 800);
    check(param_val, 30'h3);
    sel(2);
    prog_u.pulse(1'b0, 800);
    prog_u.pulse(1'b1, 100); // Glitch shorter than the filter
    prog_u.pulse(1'b0, 800);
    check(param_val, 30'h83);
    do_reset;
    check(param_val, 30'h0);
  end
  endtask : try_mode
  task blow_mode;
  begin
    do_reset;
    sel(7); // Mode pick; its last high opens the next selection
    repeat (2) prog_u.pulse(1'b0, 800);
    repeat (2) prog_u.pulse(1'b1, 800);
    repeat (4) prog_u.pulse(1'b0, 800);
    check(param_val, 30'h100);
    blow(3'h1, 3'h2);
    prog_u.pulse(1'b0, 800);
    check(param_val, 30'h100);
    do_reset;
    check(param_val, 30'h100);
  end
  endtask : blow_mode
  task lock_mode;
  begin
    do_reset;
    sel(7); // Mode pick; its last high opens the next selection
    repeat (5) prog_u.pulse(1'b0, 800);
    repeat (2) prog_u.pulse(1'b1, 800);
    prog_u.pulse(1'b0, 800);
    blow(3'h4, 3'h0);
    check(locked, 1'b1);
    do_reset;
    sel(1);
    prog_u.pulse(1'b0, 800);
    check(locked, 1'b1);
    check(param_val, 30'h1000100);
  end
  endtask : lock_mode
  initial
  begin
    try_mode;
    blow_mode;
    lock_mode;
    end_sim;
  end
  // Watchdog just past the roughly 95000 cycles of the tests
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    end_sim;
  end
endmodule : tb_supply_pulse_fuse_programmer
bind supply_pulse_fuse_programmer spf_monitor mon_u (.ref_clk(ref_clk),
  .rst_n(rst_n), .lvl_mid(lvl_mid), .lvl_high(lvl_high),
  .fuse_sense(fuse_sense), .param_val(param_val), .blow_fire(blow_fire),
  .blow_reg(blow_reg), .blow_bit(blow_bit), .locked(locked));
